/* rtl/exec_cfg.svh */
// Constants for the compact memory, stack and branch execution block
// Operation
// (RL1) Halfword store adds scaled offset to base, writes source low sixteen bits.
// (RL2) Halfword load fills destination low half, clears upper sixteen bits.
// (RL3) Halfword offset field is doubled, giving a 6-bit halfword-aligned offset.
// (RL4) Stack word transfer adds up to 1020 bytes; load bit picks direction.
// (RL5) Stack word field times four forms a 10-bit word-aligned offset.
// (RL6) Load address adds scaled field to program counter or stack pointer.
// (RL7) Program counter source is instruction address plus four, bit 1 cleared.
// (RL8) Load address leaves the status flags untouched.
// (RL9) Stack adjust is sign plus magnitude in words, up to 508 bytes.
// (RL10) Stack adjust leaves the status flags untouched.
// (RL11) Push and pop use a full descending stack, final pointer written back.
// (RL12) Push adds link register, pop adds program counter, on the extra bit.
// (RL13) Pop loads program counter last, branching, and updates the pointer.
// (RL14) Multiple transfer uses ascending words from base, then writes base back.
// (RL15) Codes 0000 to 0111 test zero, carry, negative, overflow set or clear.
// (RL16) Code 1000 branches when carry set and zero clear.
// (RL17) Branch target uses program counter four bytes ahead.
// (RL18) Each instruction takes the cycles of its full-width equivalent.
// (RL19) Codes 1001 to 1101 give signed and unsigned compare branches.
// (RL20) Code 1110 is undefined; code 1111 is a software interrupt.
// (RL21) Branch offset is sign-extended and doubled; failing branch falls through.
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH
// ==========================================
// Opcode groups and fields
`define OP_HALF 4'h8
`define OP_SPREL 4'h9
`define OP_LADR 4'ha
`define OP_MISC 4'hb
`define OP_MULTI 4'hc
`define OP_BCOND 4'hd
`define F_OP 15:12
`define F_LOAD 11
`define F_OFF5 10:6
`define F_BASE 5:3
`define F_RD 2:0
`define F_RHI 10:8
`define F_SCALED_WORD_FIELD 7:0
`define F_ADJ_SIGN 7
`define F_ADJ_MAG 6:0
`define F_MISC_SUB 11:8
`define MISC_ADJ 4'h0
`define F_PP_KEY 10:9
`define PP_KEY 2'h2
`define F_EXTRA 8
`define F_LIST 7:0
`define F_COND 11:8
`define F_SOFF8 7:0
`define F_SOFF_SIGN 7
// ==========================================
// Registers, masks and condition codes
`define REG_SP 4'hd
`define REG_LR 4'he
`define LIST_W 9
`define LIST_EXTRA 4'h8
`define PC_AHEAD 32'h4
`define WORD_STEP 32'h4
`define PC_BIT1_MASK 32'hffff_fffd
`define HALF_MASK 32'h0000_ffff
`define COND_EQ 4'h0
`define COND_NE 4'h1
`define COND_CS 4'h2
`define COND_CC 4'h3
`define COND_MI 4'h4
`define COND_PL 4'h5
`define COND_VS 4'h6
`define COND_VC 4'h7
`define COND_HI 4'h8
`define COND_LS 4'h9
`define COND_GE 4'ha
`define COND_LT 4'hb
`define COND_GT 4'hc
`define COND_LE 4'hd
`define COND_UNDEF 4'he
`define COND_SWI 4'hf
`endif

/* rtl/exec_pkg.sv */
// Types for the compact memory, stack and branch execution block
package exec_pkg;
	// ==========================================
	// Types
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_EXEC = 4'h2,
		ST_XFER = 4'h4,
		ST_WBACK = 4'h8
	} state_t;
	typedef struct packed {
		logic n;
		logic z;
		logic c;
		logic v;
	} nzcv_t;
endpackage

/* rtl/exec_if.sv */
// Interfaces between the execution block and its helpers
`timescale 1ns/100ps
`include "exec_cfg.svh"
interface cond_if;
	logic [3:0] cond;
	exec_pkg::nzcv_t flags;
	logic taken;
	logic undef;
	logic swi;
	modport eval (input cond, input flags, output taken, output undef, output swi);
	modport user (output cond, output flags, input taken, input undef, input swi);
endinterface

interface list_if;
	logic [`LIST_W-1:0] list;
	logic [3:0] lowIdx;
	logic [3:0] count;
	modport scan (input list, output lowIdx, output count);
	modport user (output list, input lowIdx, input count);
endinterface

/* rtl/cond_eval.sv */
// Branch condition evaluation
`timescale 1ns/100ps
`include "exec_cfg.svh"
module cond_eval (
	cond_if.eval ce
);
	// ==========================================
	// Condition table
	always_comb
	begin
		ce.taken = 1'b0;
		ce.undef = 1'b0;
		ce.swi = 1'b0;
		unique case (ce.cond)
			`COND_EQ: ce.taken = ce.flags.z; // RL15
			`COND_NE: ce.taken = !ce.flags.z; // RL15
			`COND_CS: ce.taken = ce.flags.c; // RL15
			`COND_CC: ce.taken = !ce.flags.c; // RL15
			`COND_MI: ce.taken = ce.flags.n; // RL15
			`COND_PL: ce.taken = !ce.flags.n; // RL15
			`COND_VS: ce.taken = ce.flags.v; // RL15
			`COND_VC: ce.taken = !ce.flags.v; // RL15
			`COND_HI: ce.taken = ce.flags.c && !ce.flags.z; // RL16
			`COND_LS: ce.taken = !ce.flags.c || ce.flags.z; // RL19
			`COND_GE: ce.taken = ce.flags.n == ce.flags.v; // RL19
			`COND_LT: ce.taken = ce.flags.n != ce.flags.v; // RL19
			`COND_GT: ce.taken = !ce.flags.z && (ce.flags.n == ce.flags.v); // RL19
			`COND_LE: ce.taken = ce.flags.z || (ce.flags.n != ce.flags.v); // RL19
			`COND_UNDEF: ce.undef = 1'b1; // RL20
			`COND_SWI: ce.swi = 1'b1; // RL20
		endcase
	end
endmodule

/* rtl/list_scan.sv */
// Register list scanner: lowest set entry and entry count
`timescale 1ns/100ps
`include "exec_cfg.svh"
module list_scan #(
	parameter int W = `LIST_W
) (
	list_if.scan ls
);
	// ==========================================
	// Scan from the top so the lowest entry wins
	always_comb
	begin
		ls.lowIdx = 4'h0;
		ls.count = 4'h0;
		for (int i = W - 1; i >= 0; i--)
		begin
			if (ls.list[i])
			begin
				ls.lowIdx = 4'(i);
			end
			ls.count = ls.count + 4'({3'h0, ls.list[i]});
		end
	end
endmodule

/* rtl/compact_exec.sv */
// Execution of compact halfword, stack, multiple-transfer and branch instructions
`timescale 1ns/100ps
`include "exec_cfg.svh"
module compact_exec (
	input wire logic mclk,
	input wire logic rst,
	input wire logic instrValid,
	input wire logic [15:0] instr,
	input wire logic [31:0] instrAddr,
	output logic instrReady,
	input wire logic [3:0] flagsIn,
	output logic [3:0] rdAddrA,
	input wire logic [31:0] rdDataA,
	output logic [3:0] rdAddrB,
	input wire logic [31:0] rdDataB,
	output logic wrEn,
	output logic [3:0] wrIdx,
	output logic [31:0] wrData,
	output logic memReq,
	output logic memWrite,
	output logic memHalf,
	output logic [31:0] memAddr,
	output logic [31:0] memWdata,
	input wire logic memAck,
	input wire logic [31:0] memRdata,
	output logic pcLoad,
	output logic [31:0] pcTarget,
	output logic swiReq,
	output logic undefInstr
);
	// ==========================================
	// Helpers
	function automatic logic [3:0] regOf(input logic [3:0] idx);
		regOf = (idx == `LIST_EXTRA) ? `REG_LR : idx;
	endfunction

	function automatic logic [`LIST_W-1:0] dropLow(input logic [`LIST_W-1:0] l);
		dropLow = l & (l - `LIST_W'(1));
	endfunction

	// ==========================================
	// State
	exec_pkg::state_t state_reg, state_next;
	logic [15:0] instr_reg, instr_next;
	logic [31:0] pc_reg, pc_next;
	logic [`LIST_W-1:0] list_reg, list_next;
	logic [3:0] curIdx_reg, curIdx_next;
	logic load_reg, load_next;
	logic multi_reg, multi_next;
	logic pop_reg, pop_next;
	logic [3:0] baseIdx_reg, baseIdx_next;
	logic [31:0] baseFinal_reg, baseFinal_next;
	logic memReq_reg, memReq_next;
	logic memWrite_reg, memWrite_next;
	logic memHalf_reg, memHalf_next;
	logic [31:0] memAddr_reg, memAddr_next;
	logic [31:0] memWdata_reg, memWdata_next;
	logic wrEn_reg, wrEn_next;
	logic [3:0] wrIdx_reg, wrIdx_next;
	logic [31:0] wrData_reg, wrData_next;
	logic pcLoad_reg, pcLoad_next;
	logic [31:0] pcTarget_reg, pcTarget_next;
	logic swi_reg, swi_next;
	logic undef_reg, undef_next;

	// ==========================================
	// Decode
	logic [3:0] op;
	logic isPushPop, isAdjust, isXfer;
	logic [`LIST_W-1:0] decList;
	logic [31:0] pcAhead, halfOff, wordOff, adjOff, branchOff;
	cond_if cf();
	list_if ls();

	assign op = instr_reg[`F_OP];
	assign isAdjust = (op == `OP_MISC) && (instr_reg[`F_MISC_SUB] == `MISC_ADJ);
	assign isPushPop = (op == `OP_MISC) && (instr_reg[`F_PP_KEY] == `PP_KEY);
	assign isXfer = (op == `OP_HALF) || (op == `OP_SPREL) || (op == `OP_MULTI) || isPushPop;
	assign pcAhead = pc_reg + `PC_AHEAD; // RL17
	assign halfOff = {26'h0, instr_reg[`F_OFF5], 1'b0}; // RL3
	assign wordOff = {22'h0, instr_reg[`F_SCALED_WORD_FIELD], 2'b00}; // RL5
	assign adjOff = {23'h0, instr_reg[`F_ADJ_MAG], 2'b00}; // RL9
	assign branchOff = {{23{instr_reg[`F_SOFF_SIGN]}}, instr_reg[`F_SOFF8], 1'b0}; // RL21

	always_comb
	begin
		decList = '0;
		unique case (op)
			`OP_HALF: decList[instr_reg[`F_RD]] = 1'b1;
			`OP_SPREL: decList[instr_reg[`F_RHI]] = 1'b1;
			`OP_MULTI: decList[7:0] = instr_reg[`F_LIST];
			default:
			begin
				if (isPushPop)
				begin
					decList = {instr_reg[`F_EXTRA], instr_reg[`F_LIST]}; // RL12
				end
			end
		endcase
	end

	assign cf.cond = instr_reg[`F_COND];
	assign cf.flags = exec_pkg::nzcv_t'(flagsIn);
	cond_eval condUnit (
		.ce(cf.eval)
	);

	// Scan the decoded list on entry, then the remaining list while transferring
	assign ls.list = (state_reg == exec_pkg::ST_EXEC) ? decList : list_reg;
	list_scan #(
		.W(`LIST_W)
	) scanUnit (
		.ls(ls.scan)
	);

	// Store data always comes from the next entry so it can be registered ahead
	assign rdAddrA = regOf(ls.lowIdx);
	always_comb
	begin
		rdAddrB = `REG_SP;
		if ((op == `OP_HALF) && (state_reg == exec_pkg::ST_EXEC))
		begin
			rdAddrB = {1'b0, instr_reg[`F_BASE]};
		end
		else if ((op == `OP_MULTI) && (state_reg == exec_pkg::ST_EXEC))
		begin
			rdAddrB = {1'b0, instr_reg[`F_RHI]};
		end
	end

	// ==========================================
	// Next state
	always_comb
	begin
		logic [31:0] startAddr;
		logic [31:0] span;
		startAddr = rdDataB;
		span = {26'h0, ls.count, 2'b00};
		state_next = state_reg;
		instr_next = instr_reg;
		pc_next = pc_reg;
		list_next = list_reg;
		curIdx_next = curIdx_reg;
		load_next = load_reg;
		multi_next = multi_reg;
		pop_next = pop_reg;
		baseIdx_next = baseIdx_reg;
		baseFinal_next = baseFinal_reg;
		memReq_next = memReq_reg;
		memWrite_next = memWrite_reg;
		memHalf_next = memHalf_reg;
		memAddr_next = memAddr_reg;
		memWdata_next = memWdata_reg;
		wrEn_next = 1'b0;
		wrIdx_next = wrIdx_reg;
		wrData_next = wrData_reg;
		pcLoad_next = 1'b0;
		pcTarget_next = pcTarget_reg;
		swi_next = 1'b0;
		undef_next = 1'b0;
		unique case (state_reg)
			exec_pkg::ST_IDLE:
			begin
				if (instrValid)
				begin
					instr_next = instr;
					pc_next = instrAddr;
					state_next = exec_pkg::ST_EXEC;
				end
			end
			exec_pkg::ST_EXEC:
			begin
				state_next = exec_pkg::ST_IDLE;
				load_next = instr_reg[`F_LOAD]; // RL4
				memHalf_next = (op == `OP_HALF);
				multi_next = (op == `OP_MULTI) || isPushPop;
				pop_next = isPushPop && instr_reg[`F_LOAD];
				baseIdx_next = (op == `OP_MULTI) ? {1'b0, instr_reg[`F_RHI]} : `REG_SP;
				baseFinal_next = rdDataB + span; // RL11 RL14
				if (op == `OP_HALF)
				begin
					startAddr = rdDataB + halfOff; // RL1 RL2
				end
				else if (op == `OP_SPREL)
				begin
					startAddr = rdDataB + wordOff; // RL4
				end
				else if (isPushPop && !instr_reg[`F_LOAD])
				begin
					// Lowest address first: same words as decrementing before each store
					startAddr = rdDataB - span; // RL11
					baseFinal_next = rdDataB - span; // RL11
				end
				if (isXfer)
				begin
					if (decList != '0)
					begin
						state_next = exec_pkg::ST_XFER; // RL18
						memReq_next = 1'b1;
						memWrite_next = !instr_reg[`F_LOAD];
						memAddr_next = startAddr;
						memWdata_next = (op == `OP_HALF) ? (rdDataA & `HALF_MASK) : rdDataA; // RL1
						curIdx_next = ls.lowIdx;
						list_next = dropLow(decList);
					end
				end
				else if (op == `OP_LADR)
				begin
					// No flag write path exists in this block
					wrEn_next = 1'b1; // RL8
					wrIdx_next = {1'b0, instr_reg[`F_RHI]};
					if (instr_reg[`F_LOAD])
					begin
						wrData_next = rdDataB + wordOff; // RL6
					end
					else
					begin
						wrData_next = (pcAhead & `PC_BIT1_MASK) + wordOff; // RL6 RL7
					end
				end
				else if (isAdjust)
				begin
					wrEn_next = 1'b1; // RL10
					wrIdx_next = `REG_SP;
					wrData_next = instr_reg[`F_ADJ_SIGN] ? (rdDataB - adjOff) : (rdDataB + adjOff); // RL9
				end
				else if (op == `OP_BCOND)
				begin
					pcLoad_next = cf.taken; // RL15 RL16 RL19 RL21
					pcTarget_next = pcAhead + branchOff; // RL17 RL21
					swi_next = cf.swi; // RL20
					undef_next = cf.undef; // RL20
				end
				else
				begin
					// Other formats belong to neighbouring decoders
					undef_next = 1'b1;
				end
			end
			exec_pkg::ST_XFER:
			begin
				if (memAck)
				begin
					if (load_reg)
					begin
						if (pop_reg && (curIdx_reg == `LIST_EXTRA))
						begin
							pcLoad_next = 1'b1; // RL13
							pcTarget_next = memRdata; // RL13
						end
						else
						begin
							wrEn_next = 1'b1;
							wrIdx_next = curIdx_reg;
							wrData_next = memHalf_reg ? (memRdata & `HALF_MASK) : memRdata; // RL2
						end
					end
					memAddr_next = memAddr_reg + `WORD_STEP; // RL14
					if (list_reg == '0)
					begin
						memReq_next = 1'b0;
						state_next = multi_reg ? exec_pkg::ST_WBACK : exec_pkg::ST_IDLE; // RL18
					end
					else
					begin
						memWdata_next = rdDataA; // RL12
						curIdx_next = ls.lowIdx;
						list_next = dropLow(list_reg);
					end
				end
			end
			exec_pkg::ST_WBACK:
			begin
				// Writeback last, so a base that was also loaded ends with the new address
				wrEn_next = 1'b1; // RL11 RL13 RL14
				wrIdx_next = baseIdx_reg;
				wrData_next = baseFinal_reg;
				state_next = exec_pkg::ST_IDLE;
			end
		endcase
	end

	// ==========================================
	// Registers
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= exec_pkg::ST_IDLE;
			instr_reg <= 16'h0;
			pc_reg <= 32'h0;
			list_reg <= '0;
			curIdx_reg <= 4'h0;
			load_reg <= 1'b0;
			multi_reg <= 1'b0;
			pop_reg <= 1'b0;
			baseIdx_reg <= 4'h0;
			baseFinal_reg <= 32'h0;
			memReq_reg <= 1'b0;
			memWrite_reg <= 1'b0;
			memHalf_reg <= 1'b0;
			memAddr_reg <= 32'h0;
			memWdata_reg <= 32'h0;
			wrEn_reg <= 1'b0;
			wrIdx_reg <= 4'h0;
			wrData_reg <= 32'h0;
			pcLoad_reg <= 1'b0;
			pcTarget_reg <= 32'h0;
			swi_reg <= 1'b0;
			undef_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			instr_reg <= instr_next;
			pc_reg <= pc_next;
			list_reg <= list_next;
			curIdx_reg <= curIdx_next;
			load_reg <= load_next;
			multi_reg <= multi_next;
			pop_reg <= pop_next;
			baseIdx_reg <= baseIdx_next;
			baseFinal_reg <= baseFinal_next;
			memReq_reg <= memReq_next;
			memWrite_reg <= memWrite_next;
			memHalf_reg <= memHalf_next;
			memAddr_reg <= memAddr_next;
			memWdata_reg <= memWdata_next;
			wrEn_reg <= wrEn_next;
			wrIdx_reg <= wrIdx_next;
			wrData_reg <= wrData_next;
			pcLoad_reg <= pcLoad_next;
			pcTarget_reg <= pcTarget_next;
			swi_reg <= swi_next;
			undef_reg <= undef_next;
		end
	end

	assign instrReady = (state_reg == exec_pkg::ST_IDLE);
	assign memReq = memReq_reg;
	assign memWrite = memWrite_reg;
	assign memHalf = memHalf_reg;
	assign memAddr = memAddr_reg;
	assign memWdata = memWdata_reg;
	assign wrEn = wrEn_reg;
	assign wrIdx = wrIdx_reg;
	assign wrData = wrData_reg;
	assign pcLoad = pcLoad_reg;
	assign pcTarget = pcTarget_reg;
	assign swiReq = swi_reg;
	assign undefInstr = undef_reg;

	// ==========================================
	// Checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	logic inExec;
	assign inExec = (state_reg == exec_pkg::ST_EXEC);

	AST_HALF_STORE: assert property ( // RL1
		memReq && memWrite && memHalf |-> memWdata[31:16] == 16'h0)
		else $error("halfword store drives upper data bits");
	AST_HALF_LOAD: assert property ( // RL2
		(state_reg == exec_pkg::ST_XFER) && memAck && load_reg && memHalf_reg
		|=> wrEn && wrData == {16'h0, $past(memRdata[15:0])})
		else $error("halfword load not zero extended");
	AST_HALF_ADDR: assert property ( // RL3
		inExec && (op == `OP_HALF)
		|=> memReq && memAddr == $past(rdDataB) + {26'h0, $past(instr_reg[`F_OFF5]), 1'b0})
		else $error("halfword address wrong");
	AST_SPREL_ADDR: assert property ( // RL4
		inExec && (op == `OP_SPREL)
		|=> memReq && (memAddr - $past(rdDataB)) <= 32'h3fc && memWrite == !$past(instr_reg[`F_LOAD]))
		else $error("stack relative transfer wrong");
	AST_SPREL_ALIGN: assert property ( // RL5
		inExec && (op == `OP_SPREL) |=> memAddr[1:0] == $past(rdDataB[1:0]))
		else $error("stack relative offset not word aligned");
	AST_LADR_PC: assert property ( // RL7
		inExec && (op == `OP_LADR) && !instr_reg[`F_LOAD]
		|=> wrEn && wrData == ((($past(pc_reg) + 32'h4) & 32'hffff_fffd) + {22'h0, $past(instr_reg[7:0]), 2'b00}))
		else $error("load address from program counter wrong");
	AST_ADJUST: assert property ( // RL9
		inExec && isAdjust && instr_reg[`F_ADJ_SIGN]
		|=> wrEn && wrIdx == `REG_SP && $past(rdDataB) - wrData == {23'h0, $past(instr_reg[6:0]), 2'b00})
		else $error("stack adjust wrong");
	AST_PUSH_START: assert property ( // RL11
		inExec && isPushPop && !instr_reg[`F_LOAD] && decList != '0
		|=> memAddr == $past(rdDataB) - {26'h0, $past(ls.count), 2'b00})
		else $error("push start address wrong");
	AST_BRANCH_EQUAL: assert property ( // RL15
		inExec && (op == `OP_BCOND) && cf.cond == `COND_EQ |=> pcLoad == $past(flagsIn[2]))
		else $error("equal branch wrong");
	AST_BRANCH_HIGHER: assert property ( // RL16
		inExec && (op == `OP_BCOND) && cf.cond == `COND_HI |=> pcLoad == ($past(flagsIn[1]) && !$past(flagsIn[2])))
		else $error("unsigned higher branch wrong");
	AST_BGE: assert property ( // RL19
		inExec && (op == `OP_BCOND) && cf.cond == `COND_GE |=> pcLoad == ($past(flagsIn[3]) == $past(flagsIn[0])))
		else $error("greater or equal branch wrong");
	AST_TARGET: assert property ( // RL17
		inExec && (op == `OP_BCOND) |=> pcTarget == $past(pc_reg) + 32'h4 + $past(branchOff))
		else $error("branch target wrong");
	AST_UNDEF: assert property ( // RL20
		inExec && (op == `OP_BCOND) && cf.cond >= `COND_UNDEF
		|=> !pcLoad && (undefInstr != swiReq))
		else $error("undefined or interrupt code mishandled");
	AST_WBACK: assert property ( // RL14
		(state_reg == exec_pkg::ST_WBACK) |=> wrEn && wrIdx == $past(baseIdx_reg) && state_reg == exec_pkg::ST_IDLE)
		else $error("base writeback missing");
	AST_SINGLE_DONE: assert property ( // RL18
		(state_reg == exec_pkg::ST_XFER) && memAck && list_reg == '0 && !multi_reg
		|=> instrReady && !memReq)
		else $error("single transfer did not finish");

	COV_PUSH_LR: cover property (inExec && isPushPop && !instr_reg[`F_LOAD] && instr_reg[`F_EXTRA]);
	COV_POP_PC: cover property ((state_reg == exec_pkg::ST_XFER) && pop_reg ##1 pcLoad);
	COV_BRANCH: cover property (inExec && (op == `OP_BCOND) ##1 pcLoad);
	COV_SWI: cover property (swiReq);
endmodule

/* test/exec_partner.sv */
// Register file and memory model facing the execution block
`timescale 1ns/100ps
module exec_partner (
	input wire logic mclk,
	input wire logic [3:0] rdAddrA,
	output logic [31:0] rdDataA,
	input wire logic [3:0] rdAddrB,
	output logic [31:0] rdDataB,
	input wire logic wrEn,
	input wire logic [3:0] wrIdx,
	input wire logic [31:0] wrData,
	input wire logic memReq,
	input wire logic memWrite,
	input wire logic memHalf,
	input wire logic [31:0] memAddr,
	input wire logic [31:0] memWdata,
	output logic memAck,
	output logic [31:0] memRdata
);
	// ==========================================
	// Storage
	logic [31:0] regs [0:15];
	logic [31:0] mem [int];
	logic [31:0] addrLog [$];
	int lat = 0;
	int cnt = 0;
	logic [31:0] w;
	assign rdDataA = regs[rdAddrA];
	assign rdDataB = regs[rdAddrB];
	function automatic logic [31:0] rdw(input logic [31:0] a);
		return mem.exists(a[31:2]) ? mem[a[31:2]] : 32'h0;
	endfunction
	initial
	begin
		memAck = 1'b0;
		memRdata = 32'h5a5a_a5a5;
	end
	// ==========================================
	// Beats complete on the edge that sees memReq and memAck
	always @(posedge mclk)
	begin
		if (wrEn)
			regs[wrIdx] <= wrData;
		if (memReq && memAck)
		begin
			addrLog.push_back(memAddr);
			w = rdw(memAddr);
			if (!memHalf)
				w = memWdata;
			else if (memAddr[1])
				w[31:16] = memWdata[15:0];
			else
				w[15:0] = memWdata[15:0];
			if (memWrite)
				mem[memAddr[31:2]] = w;
		end
		#1;
		// Read data toggles outside an answer so stale values never pass
		if (memAck)
		begin
			memAck = 1'b0;
			cnt = 0;
			memRdata = ~memRdata;
		end
		else if (memReq && cnt < lat)
		begin
			cnt++;
			memRdata = ~memRdata;
		end
		else if (memReq)
		begin
			memAck = 1'b1;
			w = rdw(memAddr);
			// Upper half carries junk so a missing clear shows up
			memRdata = !memHalf ? w : memAddr[1] ? {~w[31:16], w[31:16]} : {~w[15:0], w[15:0]};
		end
		else
			memRdata = ~memRdata;
	end
endmodule

/* test/testbench.sv */
// Self-checking bench for the compact execution block
`timescale 1ns/100ps
`include "exec_cfg.svh"
module testbench;
	// ==========================================
	// Signals
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic instrValid = 1'b0;
	logic [15:0] instr = 16'h0;
	logic [31:0] instrAddr = 32'h0;
	logic [3:0] flagsIn = 4'h0;
	logic instrReady, wrEn, memReq, memWrite, memHalf, memAck, pcLoad, swiReq, undefInstr;
	logic [3:0] rdAddrA, rdAddrB, wrIdx;
	logic [31:0] rdDataA, rdDataB, wrData, memAddr, memWdata, memRdata, pcTarget, lastTgt;
	int err_total = 0;
	int tests_run = 0;
	int cyc, pcSeen = 0, swiSeen = 0, udSeen = 0;
	always #5 mclk = ~mclk;
	compact_exec i_dut (.mclk(mclk), .rst(rst), .instrValid(instrValid), .instr(instr), .instrAddr(instrAddr),
		.instrReady(instrReady), .flagsIn(flagsIn), .rdAddrA(rdAddrA), .rdDataA(rdDataA), .rdAddrB(rdAddrB),
		.rdDataB(rdDataB), .wrEn(wrEn), .wrIdx(wrIdx), .wrData(wrData), .memReq(memReq), .memWrite(memWrite),
		.memHalf(memHalf), .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata),
		.pcLoad(pcLoad), .pcTarget(pcTarget), .swiReq(swiReq), .undefInstr(undefInstr));
	exec_partner i_env (.mclk(mclk), .rdAddrA(rdAddrA), .rdDataA(rdDataA), .rdAddrB(rdAddrB), .rdDataB(rdDataB),
		.wrEn(wrEn), .wrIdx(wrIdx), .wrData(wrData), .memReq(memReq), .memWrite(memWrite), .memHalf(memHalf),
		.memAddr(memAddr), .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata));
	always @(posedge mclk)
	begin
		if (pcLoad === 1'b1)
		begin
			pcSeen++;
			lastTgt = pcTarget;
		end
		if (swiReq === 1'b1)
			swiSeen++;
		if (undefInstr === 1'b1)
			udSeen++;
	end
	// ==========================================
	// Shared tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Offers one instruction, counts cycles until ready, then lets the last write land
	task automatic run(input logic [15:0] ins, input logic [31:0] adr);
		instr = ins;
		instrAddr = adr;
		instrValid = 1'b1;
		@(posedge mclk);
		#1;
		instrValid = 1'b0;
		cyc = 1;
		while (instrReady !== 1'b1 && cyc < 300)
		begin
			@(posedge mclk);
			#1;
			cyc++;
		end
		@(posedge mclk);
		#1;
	endtask
	// ==========================================
	// Scenarios
	task automatic t_half();
		i_env.regs[1] = 32'h100;
		i_env.regs[2] = 32'h1234_beef;
		i_env.regs[4] = 32'hffff_ffff;
		i_env.addrLog.delete();
		run({`OP_HALF, 1'b0, 5'h1f, 3'h1, 3'h2}, 32'h0);
		check("half addr", i_env.addrLog[0], 32'h13e);
		check("half mem", i_env.rdw(32'h13c) & 32'hffff_0000, 32'hbeef_0000);
		check("half cycles", cyc, 3);
		run({`OP_HALF, 1'b1, 5'h1f, 3'h1, 3'h4}, 32'h0);
		check("half load", i_env.regs[4], 32'h0000_beef);
		$display("test half done");
	endtask
	task automatic t_sprel();
		i_env.regs[13] = 32'h2000;
		i_env.regs[3] = 32'hcafe_0003;
		i_env.addrLog.delete();
		run({`OP_SPREL, 1'b0, 3'h3, 8'hff}, 32'h0);
		check("sp addr", i_env.addrLog[0], 32'h23fc);
		run({`OP_SPREL, 1'b1, 3'h5, 8'hff}, 32'h0);
		check("sp load", i_env.regs[5], 32'hcafe_0003);
		$display("test sprel done");
	endtask
	task automatic t_ladr();
		run({`OP_LADR, 1'b0, 3'h6, 8'h8f}, 32'h1002);
		check("pc addr", i_env.regs[6], 32'h1240);
		check("ladr cycles", cyc, 2);
		run({`OP_LADR, 1'b1, 3'h6, 8'h35}, 32'h1002);
		check("sp addr", i_env.regs[6], 32'h20d4);
		run({`OP_MISC, `MISC_ADJ, 1'b0, 7'h7f}, 32'h0);
		check("sp add", i_env.regs[13], 32'h21fc);
		run({`OP_MISC, `MISC_ADJ, 1'b1, 7'h7f}, 32'h0);
		run({`OP_MISC, `MISC_ADJ, 1'b1, 7'h1a}, 32'h0);
		check("sp sub", i_env.regs[13], 32'h1f98);
		$display("test ladr done");
	endtask
	task automatic t_stack();
		int i;
		i_env.regs[13] = 32'h2000;
		i_env.regs[0] = 32'ha0;
		i_env.regs[2] = 32'ha2;
		i_env.regs[7] = 32'ha7;
		i_env.regs[14] = 32'h1234;
		i_env.lat = 2;
		i_env.addrLog.delete();
		run({`OP_MISC, 1'b0, `PP_KEY, 1'b1, 8'h85}, 32'h0);
		for (i = 0; i < 4; i++)
			check("push addr", i_env.addrLog[i], 32'h1ff0 + 4 * i);
		check("push lr", i_env.rdw(32'h1ffc), 32'h1234);
		check("push r7", i_env.rdw(32'h1ff8), 32'ha7);
		check("push sp", i_env.regs[13], 32'h1ff0);
		i_env.regs[0] = 32'h0;
		i_env.regs[7] = 32'h0;
		i = pcSeen;
		run({`OP_MISC, 1'b1, `PP_KEY, 1'b1, 8'h85}, 32'h0);
		check("pop r0", i_env.regs[0], 32'ha0);
		check("pop r7", i_env.regs[7], 32'ha7);
		check("pop pc", pcSeen - i, 1);
		check("pop target", lastTgt, 32'h1234);
		check("pop sp", i_env.regs[13], 32'h2000);
		i_env.lat = 0;
		$display("test stack done");
	endtask
	task automatic t_multi();
		i_env.regs[1] = 32'h3000;
		i_env.addrLog.delete();
		run({`OP_MULTI, 1'b0, 3'h1, 8'hf8}, 32'h0);
		check("stm last", i_env.addrLog[4], 32'h3010);
		check("stm base", i_env.regs[1], 32'h3014);
		i_env.regs[1] = 32'h3000;
		run({`OP_MULTI, 1'b1, 3'h1, 8'h0d}, 32'h0);
		check("ldm r2", i_env.regs[2], i_env.rdw(32'h3004));
		check("ldm base", i_env.regs[1], 32'h300c);
		i_env.addrLog.delete();
		run({`OP_MULTI, 1'b0, 3'h1, 8'h00}, 32'h0);
		check("empty beats", i_env.addrLog.size(), 0);
		check("empty base", i_env.regs[1], 32'h300c);
		$display("test multi done");
	endtask
	task automatic t_branch();
		logic [3:0] f, c;
		logic n, z, k, v, tk;
		logic [31:0] tgt;
		int p, s, u;
		for (int i = 0; i < 256; i++)
		begin
			{f, c} = i[7:0];
			{n, z, k, v} = f;
			flagsIn = f;
			case (c)
				4'h0: tk = z;
				4'h1: tk = !z;
				4'h2: tk = k;
				4'h3: tk = !k;
				4'h4: tk = n;
				4'h5: tk = !n;
				4'h6: tk = v;
				4'h7: tk = !v;
				4'h8: tk = k && !z;
				4'h9: tk = !k || z;
				4'ha: tk = n == v;
				4'hb: tk = n != v;
				4'hc: tk = !z && n == v;
				4'hd: tk = z || n != v;
				default: tk = 1'b0;
			endcase
			tgt = f[0] ? 32'h4102 : 32'h3f04;
			{p, s, u} = {pcSeen, swiSeen, udSeen};
			run({`OP_BCOND, c, f[0] ? 8'h7f : 8'h80}, 32'h4000);
			check("taken", pcSeen - p, tk);
			if (tk)
				check("target", lastTgt, tgt);
			check("swi", swiSeen - s, c == 4'hf);
			check("undef", udSeen - u, c == 4'he);
		end
		{p, u} = {pcSeen, udSeen};
		run(16'h0000, 32'h0);
		check("other undef", udSeen - u, 1);
		check("other taken", pcSeen - p, 0);
		$display("test branch done");
	endtask
	task automatic t_reset();
		i_env.lat = 3;
		instr = {`OP_MULTI, 1'b0, 3'h1, 8'hff};
		instrValid = 1'b1;
		@(posedge mclk);
		#1;
		instrValid = 1'b0;
		repeat (4) @(posedge mclk);
		#1;
		rst = 1'b1;
		#1;
		check("rst memReq", memReq, 1'b0);
		check("rst ready", instrReady, 1'b1);
		check("rst base", rdAddrB, 4'hd);
		@(posedge mclk);
		#1;
		rst = 1'b0;
		i_env.lat = 0;
		$display("test reset done");
	endtask
	// ==========================================
	// Main sequence and watchdog
	initial
	begin
		repeat (2) @(posedge mclk);
		#1;
		rst = 1'b0;
		t_half();
		t_sprel();
		t_ladr();
		t_stack();
		t_multi();
		t_branch();
		t_reset();
		test_done();
	end
	initial
	begin
		#200000;
		err_total++;
		test_done();
	end
endmodule
